// [test/tuin_msi_slave.sv]
// message write bus model: slow accept, delayed response, optional abort
`timescale 1ns/10ps
`default_nettype none
module tuin_msi_slave (
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              valid_i,
  input  wire tuin_pkg::tuin_msi_req_t req_i,
  input  wire logic              abort_i,
  output logic                   ready_o,
  output logic                   resp_o,
  output logic                   abt_o,
  output tuin_pkg::tuin_msi_req_t last_o,
  output int                     count_o
);
  logic [3:0] wcnt;
  logic [3:0] rcnt;
  logic       busy;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {ready_o, resp_o, abt_o, busy, wcnt, rcnt} <= '0;
      last_o <= '0;
      count_o <= 0;
    end else begin
      ready_o <= 1'b0;
      resp_o <= 1'b0;
      abt_o <= ~abt_o;
      if (valid_i && ready_o) begin
        last_o <= req_i;
        count_o <= count_o + 1;
        busy <= 1'b1;
        rcnt <= 4'h3;
        wcnt <= 4'h0;
      end else if (valid_i && !busy) begin
        wcnt <= wcnt + 4'h1;
        ready_o <= (wcnt == 4'h2);
      end
      if (busy) begin
        rcnt <= rcnt - 4'h1;
        if (rcnt == 4'h1) begin
          resp_o <= 1'b1;
          abt_o <= abort_i;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [test/tuin_notifier_tb.sv]
// self-checking bench for the interrupt notifier
`timescale 1ns/10ps
`default_nettype none
module tuin_notifier_tb;
  localparam logic [15:0] DEVID = 16'h0a5a; // arbitrary value
  logic clk, rst_n, we, re, rdy, rv, ra, ab, mv;
  logic [7:0] addr;
  logic [31:0] wd, rdat;
  logic [1:0][7:0] prod, cons, ccons;
  logic [1:0] sd, si, srdy;
  logic [1:0][31:0] sa, sdat;
  logic [1:0][3:0] gs;
  logic [5:0] irq;
  logic [15:0] sid, sido;
  tuin_pkg::tuin_msi_req_t req, last;
  int cnt, n_errors, n_tests;
  tuin_notifier #(.OWN_DEVID(DEVID)) dut (.sys_clk_i(clk),
    .resetn_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat),
    .evtq_prod_i(prod), .evtq_cons_i(cons), .sync_done_i(sd),
    .sync_irq_i(si), .sync_addr_i(sa), .sync_data_i(sdat),
    .cmdq_cons_i(ccons), .sync_ready_o(srdy), .gerr_set_i(gs),
    .irq_pulse_o(irq), .msi_valid_o(mv), .msi_req_o(req),
    .msi_ready_i(rdy), .msi_resp_valid_i(rv),
    .msi_resp_abort_i(ra), .client_sid_i(sid), .client_sid_o(sido));
  tuin_msi_slave far (.sys_clk_i(clk), .resetn_i(rst_n),
    .valid_i(mv), .req_i(req), .abort_i(ab), .ready_o(rdy),
    .resp_o(rv), .abt_o(ra), .last_o(last), .count_o(cnt));
  // ==========================================================
  // helpers
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {we, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    {re, addr} <= {1'b1, a};
    @(posedge clk);
    re <= 1'b0;
    #1 chk("rdata", e, rdat);
  endtask
  task automatic pulse(int b);
    int i;
    #1;
    for (i = 0; i < 8 && irq[b] !== 1'b1; i++) @(posedge clk) #1;
    chk("irq", 32'h1, 32'(irq[b]));
    @(posedge clk) #1;
    chk("irq gap", 32'h0, 32'(irq[b]));
  endtask
  task automatic msi(int c, logic [31:0] a, d, logic [1:0] sh, logic ns);
    int i;
    for (i = 0; i < 40 && cnt == c; i++) @(posedge clk) #1;
    chk("msi count", 32'(c + 1), 32'(cnt));
    chk("addr", a, last.addr);
    chk("data", d, last.data);
    chk("sh", 32'(sh), 32'(last.sh));
    chk("ns", 32'(ns), 32'(last.ns));
    chk("devid", 32'(DEVID), 32'(last.devid));
  endtask
  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic s_evtq();
    wr(8'h40, 32'h0000_1000);
    wr(8'h44, 32'habcd_0001);
    wr(8'h48, 32'h0000_0100);
    wr(8'h08, 32'h0000_0007);
    @(posedge clk) prod[0] <= 8'h01;
    pulse(0);
    rd(8'h20, 32'h1);
    msi(0, 32'h1000, 32'habcd_0001, 2'h2, 1'b1);
    wr(8'h40, 32'h0);
    @(posedge clk) cons[0] <= 8'h01;
    @(posedge clk) prod[0] <= 8'h02;
    pulse(0);
    repeat (10) @(posedge clk);
    chk("no msi", 32'h1, 32'(cnt));
  endtask
  task automatic s_sync();
    wr(8'h10, 32'h0000_0002);
    wr(8'h78, 32'h0000_01ff);
    @(posedge clk) {sd[1], si[1], sa[1], sdat[1], ccons[1]}
      <= {2'b11, 32'h2000, 32'h55, 8'h03};
    @(posedge clk) sd[1] <= 1'b0;
    pulse(3);
    chk("sync ready", 32'h0, 32'(srdy[1]));
    rd(8'h2c, 32'h3);
    msi(1, 32'h2000, 32'h55, 2'h1, 1'b0);
    repeat (8) @(posedge clk) #1;
    chk("sync ready", 32'h1, 32'(srdy[1]));
  endtask
  task automatic s_gerr();
    @(posedge clk) gs[0] <= 4'h1;
    pulse(4);
    gs[0] <= 4'h0;
    rd(8'h18, 32'h1);
    wr(8'h18, 32'h1);
    ab <= 1'b1;
    @(posedge clk) {sd[0], si[0], sa[0], sdat[0]} <= {2'b11, 32'h3000, 32'h9};
    @(posedge clk) sd[0] <= 1'b0;
    msi(2, 32'h3000, 32'h9, 2'h2, 1'b1);
    repeat (8) @(posedge clk);
    rd(8'h18, 32'h20);
  endtask
  task automatic s_drain();
    wr(8'h40, 32'h0000_1000);
    @(posedge clk) cons[0] <= 8'h02;
    @(posedge clk) prod[0] <= 8'h03;
    wr(8'h08, 32'h0000_0006);
    rd(8'h0c, 32'h7);
    msi(3, 32'h1000, 32'habcd_0001, 2'h2, 1'b1);
    repeat (8) @(posedge clk);
    rd(8'h0c, 32'h6);
  endtask
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #300000;
    n_errors++;
    test_done();
  end
  initial begin
    {rst_n, we, re, ab, addr, wd, prod, cons, ccons} = '0;
    {sd, si, sa, sdat, gs} = '0;
    sid = 16'h1234;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) #1;
    chk("sync ready rst", 32'h3, 32'(srdy));
    chk("sid", 32'h1234, 32'(sido));
    rd(8'h00, 32'h3);
    rd(8'h04, 32'h9);
    rd(8'h34, 32'h0);
    s_evtq();
    s_sync();
    s_gerr();
    s_drain();
    test_done();
  end
endmodule
`default_nettype wire

// [verilog/tuin_notifier.sv]
// interrupt and message notifier of the translation unit
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tuin_notifier #(
  parameter bit                HAS_WIRED  = 1'b1,
  parameter bit                HAS_MSI_NS = 1'b1,
  parameter bit                HAS_MSI_S  = 1'b1,
  parameter bit                HAS_SECURE = 1'b1,
  parameter bit                HAS_COH_ACC = 1'b0,
  parameter int                IDXW       = 8,
  parameter int                SIDW       = 16,
  // arbitrary value, stands for the system-assigned device id
  parameter logic [15:0]       OWN_DEVID  = 16'h0a5a
) (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       resetn_i,
  // register port
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [31:0]                reg_wdata_i,
  input  wire logic                       reg_we_i,
  input  wire logic                       reg_re_i,
  output logic      [31:0]                reg_rdata_o,
  // event queues, index 1 is secure
  input  wire logic [1:0][IDXW-1:0]       evtq_prod_i,
  input  wire logic [1:0][IDXW-1:0]       evtq_cons_i,
  // command queue sync completions
  input  wire logic [1:0]                 sync_done_i,
  input  wire logic [1:0]                 sync_irq_i,
  input  wire logic [1:0][31:0]           sync_addr_i,
  input  wire logic [1:0][31:0]           sync_data_i,
  input  wire logic [1:0][IDXW-1:0]       cmdq_cons_i,
  output logic      [1:0]                 sync_ready_o,
  // global error sources
  input  wire logic [1:0][3:0]            gerr_set_i,
  // wired interrupt pulses, one per source
  output logic      [5:0]                 irq_pulse_o,
  // outgoing message write bus
  output logic                            msi_valid_o,
  output tuin_pkg::tuin_msi_req_t         msi_req_o,
  input  wire logic                       msi_ready_i,
  input  wire logic                       msi_resp_valid_i,
  input  wire logic                       msi_resp_abort_i,
  // client stream id pass-through
  input  wire logic [SIDW-1:0]            client_sid_i,
  output logic      [SIDW-1:0]            client_sid_o
);
  // ==========================================================
  // elaboration checks
  if (!(HAS_WIRED || HAS_MSI_NS || HAS_MSI_S)) begin : g_chk_mech
    $error("no interrupt mechanism configured");
  end
  if (IDXW < 1 || IDXW > 32 || SIDW < 1) begin : g_chk_width
    $error("unsupported index or stream id width");
  end

  // ==========================================================
  // functions
  function automatic logic [2:0] first_set(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = tuin_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] eff_sh(input logic [7:0] mt,
                                        input logic [1:0] sh);
    if (mt[7:4] == 4'h0 || mt == tuin_pkg::MT_NORMAL_NC) begin
      return tuin_pkg::SH_OSH;
    end
    return sh;
  endfunction

  function automatic logic msi_ok(input logic sec);
    return sec ? (HAS_MSI_S && HAS_SECURE) : HAS_MSI_NS;
  endfunction
  function automatic logic slot_hit(input logic [7:0] a);
    return 4'(a[7:4] - tuin_pkg::OFF_MSI_BASE[7:4]) < 4'(tuin_pkg::NSRC);
  endfunction

  // ==========================================================
  // state
  tuin_pkg::tuin_msi_cfg_t cfg_reg [tuin_pkg::NSRC];
  tuin_pkg::tuin_msi_cfg_t cfg_next [tuin_pkg::NSRC];
  logic [1:0][2:0]             ctrl_req_reg, ctrl_req_next;
  logic [1:0][2:0]             ctrl_eff_reg, ctrl_eff_next;
  logic [1:0][6:0]             gerr_reg, gerr_next;
  logic [1:0][IDXW-1:0]        evtq_prod_reg, evtq_prod_next;
  logic [1:0][IDXW-1:0]        evtq_cons_reg, evtq_cons_next;
  logic [1:0][IDXW-1:0]        cmdq_cons_reg, cmdq_cons_next;
  logic [5:0]                  pend_reg, pend_next;
  logic [5:0]                  pulse_reg, pulse_next;
  logic [5:0]                  defer_reg, defer_next;
  logic [1:0]                  ready_reg, ready_next;
  logic [31:0]                 rdata_reg, rdata_next;
  logic [SIDW-1:0]             sid_reg;
  tuin_pkg::tuin_state_t       state_reg, state_next;
  logic [2:0]                  cur_reg, cur_next;
  logic                        valid_reg, valid_next;
  tuin_pkg::tuin_msi_req_t     req_reg, req_next;
  // internal
  logic [5:0]                  trig, en_src;
  logic [5:0]                  msi_want, grant;
  logic [5:0]                  busy_src, busy_next;
  logic [1:0][2:0]             abt_set;

  // ==========================================================
  // message write engine
  always_comb begin
    logic [2:0] s;
    s          = first_set(pend_reg);
    state_next = state_reg;
    cur_next   = cur_reg;
    valid_next = valid_reg;
    req_next   = req_reg;
    grant      = 6'h00;
    abt_set    = '0;
    case (state_reg)
      tuin_pkg::ST_IDLE: begin
        if (|pend_reg) begin
          // merged triggers send one write with the current config
          grant[s]         = 1'b1;
          cur_next         = s;
          req_next.addr    = cfg_reg[s].addr;
          req_next.data    = cfg_reg[s].data;
          req_next.memtype = cfg_reg[s].memtype;
          req_next.sh      = eff_sh(cfg_reg[s].memtype, cfg_reg[s].sh);
          req_next.ns      = ~s[0];
          req_next.devid   = OWN_DEVID;
          valid_next       = (cfg_reg[s].addr != 32'h0);
          state_next       = valid_next ? tuin_pkg::ST_REQ : tuin_pkg::ST_IDLE;
        end
      end
      tuin_pkg::ST_REQ: begin
        if (msi_ready_i) begin
          valid_next = 1'b0;
          state_next = tuin_pkg::ST_WAIT;
        end
      end
      tuin_pkg::ST_WAIT: begin
        if (msi_resp_valid_i) begin
          // an aborted write completes only with its flag set
          if (msi_resp_abort_i) begin
            abt_set[cur_reg[0]][cur_reg[2:1]] = 1'b1;
          end
          state_next = tuin_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = tuin_pkg::ST_IDLE;
        valid_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= tuin_pkg::ST_IDLE;
      cur_reg   <= 3'h0;
      valid_reg <= 1'b0;
      req_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cur_reg   <= cur_next;
      valid_reg <= valid_next;
      req_reg   <= req_next;
    end
  end

  // ==========================================================
  // triggers, enables, registers and read port
  always_comb begin
    logic [1:0][6:0] gset;
    logic [1:0][6:0] gclr;
    logic [5:0]      want;
    logic [2:0]      slot;
    for (int i = 0; i < tuin_pkg::NSRC; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    ctrl_req_next  = ctrl_req_reg;
    ctrl_eff_next  = ctrl_eff_reg;
    evtq_prod_next = evtq_prod_i;
    evtq_cons_next = evtq_cons_i;
    cmdq_cons_next = cmdq_cons_reg;
    rdata_next     = tuin_pkg::RST_WORD;
    trig           = 6'h00;
    gset           = '0;
    gclr           = '0;
    want           = 6'h00;
    slot           = 3'(reg_addr_i[7:4] - tuin_pkg::OFF_MSI_BASE[7:4]);
    for (int s = 0; s < tuin_pkg::NSRC; s++) begin
      busy_src[s] = pend_reg[s] ||
                    (state_reg != tuin_pkg::ST_IDLE && cur_reg == 3'(s));
      en_src[s]   = ctrl_eff_reg[s % 2][s / 2] && (s % 2 == 0 || HAS_SECURE);
    end
    for (int q = 0; q < 2; q++) begin
      // edge only: no pending state that software could clear
      trig[q] = (evtq_prod_reg[q] == evtq_cons_reg[q]) &&
                (evtq_prod_i[q] != evtq_cons_i[q]);
      if (sync_done_i[q]) begin
        cmdq_cons_next[q] = cmdq_cons_i[q];
        if (sync_irq_i[q]) begin
          trig[2 + q]          = 1'b1;
          cfg_next[2 + q].addr = sync_addr_i[q];
          cfg_next[2 + q].data = sync_data_i[q];
        end
      end
      gset[q] = {abt_set[q], gerr_set_i[q]};
    end
    // ---------- register writes
    if (reg_we_i) begin
      case (reg_addr_i)
        tuin_pkg::OFF_CTRL:  ctrl_req_next[0] = reg_wdata_i[2:0];
        tuin_pkg::OFF_SCTRL: begin
          if (HAS_SECURE) begin
            ctrl_req_next[1] = reg_wdata_i[2:0];
          end
        end
        tuin_pkg::OFF_GERR:  gclr[0] = reg_wdata_i[6:0];
        tuin_pkg::OFF_SGERR: gclr[1] = reg_wdata_i[6:0];
        default: begin
          if (slot_hit(reg_addr_i) && msi_ok(slot[0])) begin
            case (reg_addr_i[3:2])
              tuin_pkg::SUB_ADDR: begin
                if (slot[2:1] != 2'(tuin_pkg::K_SYNC)) begin
                  cfg_next[slot].addr = {reg_wdata_i[31:2], 2'h0};
                end
              end
              tuin_pkg::SUB_DATA: begin
                if (slot[2:1] != 2'(tuin_pkg::K_SYNC)) begin
                  cfg_next[slot].data = reg_wdata_i;
                end
              end
              tuin_pkg::SUB_ATTR: begin
                cfg_next[slot].memtype = reg_wdata_i[7:0];
                cfg_next[slot].sh      =
                  reg_wdata_i[tuin_pkg::ATTR_SH_LSB +: 2];
              end
              default: begin
              end
            endcase
          end
        end
      endcase
    end
    // ---------- global errors: set wins over clear
    for (int q = 0; q < 2; q++) begin
      gerr_next[q] = (gerr_reg[q] & ~gclr[q]) | gset[q];
      trig[4 + q]  = |(gset[q] & ~gerr_reg[q]);
    end
    if (!HAS_SECURE) begin
      trig[1]      = 1'b0;
      trig[3]      = 1'b0;
      trig[5]      = 1'b0;
      gerr_next[1] = 7'h00;
    end
    // ---------- message requests
    for (int s = 0; s < tuin_pkg::NSRC; s++) begin
      msi_want[s] = trig[s] && en_src[s] && msi_ok(s[0]) &&
                    (cfg_next[s].addr != 32'h0);
    end
    pend_next = (pend_reg & ~grant) | msi_want;
    // ---------- wired pulses, held back one cycle if back to back
    want       = (trig & en_src) | defer_reg;
    pulse_next = HAS_WIRED ? (want & ~pulse_reg) : 6'h00;
    defer_next = HAS_WIRED ? (want & pulse_reg) : 6'h00;
    // ---------- enable changes wait for that source to drain
    for (int s = 0; s < tuin_pkg::NSRC; s++) begin
      busy_next[s] = pend_next[s] ||
                     (state_next != tuin_pkg::ST_IDLE && cur_next == 3'(s));
      if (!busy_src[s] && !msi_want[s]) begin
        ctrl_eff_next[s % 2][s / 2] = ctrl_req_reg[s % 2][s / 2];
      end
    end
    for (int q = 0; q < 2; q++) begin
      ready_next[q] = !busy_next[2 + q];
    end
    // ---------- reads
    if (reg_re_i) begin
      case (reg_addr_i)
        tuin_pkg::OFF_CAP: begin
          rdata_next[tuin_pkg::CAP_MSI_BIT]    = HAS_MSI_NS;
          rdata_next[tuin_pkg::CAP_WIRED_BIT]  = HAS_WIRED;
          rdata_next[tuin_pkg::CAP_COH_ACC_BIT] = HAS_COH_ACC;
        end
        tuin_pkg::OFF_SCAP: begin
          rdata_next[tuin_pkg::CAP_MSI_BIT]    = msi_ok(1'b1);
          rdata_next[tuin_pkg::CAP_SECURE_BIT] = HAS_SECURE;
        end
        tuin_pkg::OFF_CTRL:       rdata_next[2:0] = ctrl_req_reg[0];
        tuin_pkg::OFF_CTRL_ACK:   rdata_next[2:0] = ctrl_eff_reg[0];
        tuin_pkg::OFF_SCTRL:      rdata_next[2:0] = ctrl_req_reg[1];
        tuin_pkg::OFF_SCTRL_ACK:  rdata_next[2:0] = ctrl_eff_reg[1];
        tuin_pkg::OFF_GERR:       rdata_next[6:0] = gerr_reg[0];
        tuin_pkg::OFF_SGERR:      rdata_next[6:0] = gerr_reg[1];
        tuin_pkg::OFF_EVTQ_PROD:  rdata_next[IDXW-1:0] = evtq_prod_reg[0];
        tuin_pkg::OFF_SEVTQ_PROD: rdata_next[IDXW-1:0] = evtq_prod_reg[1];
        tuin_pkg::OFF_CMDQ_CONS:  rdata_next[IDXW-1:0] = cmdq_cons_reg[0];
        tuin_pkg::OFF_SCMDQ_CONS: rdata_next[IDXW-1:0] = cmdq_cons_reg[1];
        default: begin
          if (slot_hit(reg_addr_i)) begin
            case (reg_addr_i[3:2])
              tuin_pkg::SUB_ADDR: rdata_next = cfg_reg[slot].addr;
              tuin_pkg::SUB_DATA: rdata_next = cfg_reg[slot].data;
              tuin_pkg::SUB_ATTR: begin
                rdata_next[7:0] = cfg_reg[slot].memtype;
                rdata_next[tuin_pkg::ATTR_SH_LSB +: 2] = cfg_reg[slot].sh;
              end
              default: rdata_next = tuin_pkg::RST_WORD;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < tuin_pkg::NSRC; i++) begin
        cfg_reg[i] <= '0;
      end
      ctrl_req_reg  <= '0;
      ctrl_eff_reg  <= '0;
      gerr_reg      <= '0;
      evtq_prod_reg <= '0;
      evtq_cons_reg <= '0;
      cmdq_cons_reg <= '0;
      pend_reg      <= 6'h00;
      pulse_reg     <= 6'h00;
      defer_reg     <= 6'h00;
      ready_reg     <= 2'h3;
      rdata_reg     <= tuin_pkg::RST_WORD;
      sid_reg       <= '0;
    end else begin
      for (int i = 0; i < tuin_pkg::NSRC; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      ctrl_req_reg  <= ctrl_req_next;
      ctrl_eff_reg  <= ctrl_eff_next;
      gerr_reg      <= gerr_next;
      evtq_prod_reg <= evtq_prod_next;
      evtq_cons_reg <= evtq_cons_next;
      cmdq_cons_reg <= cmdq_cons_next;
      pend_reg      <= pend_next;
      pulse_reg     <= pulse_next;
      defer_reg     <= defer_next;
      ready_reg     <= ready_next;
      rdata_reg     <= rdata_next;
      sid_reg       <= client_sid_i;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_o  = rdata_reg;
  assign irq_pulse_o  = pulse_reg;
  assign sync_ready_o = ready_reg;
  assign msi_valid_o  = valid_reg;
  assign msi_req_o    = req_reg;
  assign client_sid_o = sid_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_msi_stall;
    msi_valid_o && !msi_ready_i;
  endsequence

  sequence s_abort_resp;
    state_reg == tuin_pkg::ST_WAIT && msi_resp_valid_i && msi_resp_abort_i;
  endsequence

  a_pulse_one_cycle: assert property (
    (|irq_pulse_o) |=> !(|(irq_pulse_o & $past(irq_pulse_o))))
    else $error("wired pulse longer than one cycle");
  a_msi_ns_attr: assert property (
    msi_valid_o |-> (msi_req_o.ns == !cur_reg[0]))
    else $error("message write ns attribute wrong");
  a_msi_sh_forced: assert property (
    (msi_valid_o && (msi_req_o.memtype[7:4] == 4'h0 ||
     msi_req_o.memtype == tuin_pkg::MT_NORMAL_NC))
    |-> msi_req_o.sh == tuin_pkg::SH_OSH)
    else $error("shareability not forced to outer");
  a_msi_addr_nonzero: assert property (
    msi_valid_o |-> (msi_req_o.addr != 32'h0 && msi_req_o.devid == OWN_DEVID))
    else $error("message write with zero address");
  a_msi_req_hold: assert property (
    s_msi_stall |=> msi_valid_o && $stable(msi_req_o))
    else $error("message request changed while stalled");
  a_gerr_visible: assert property (
    irq_pulse_o[4] |-> (gerr_reg[0] != 7'h00))
    else $error("error interrupt before error flag");
  a_sync_ready_low: assert property (
    msi_want[2] |=> !sync_ready_o[0] [*2])
    else $error("sync ready while its message pending");
  a_abort_flag: assert property (
    s_abort_resp |=> gerr_reg[cur_reg[0]][tuin_pkg::GERR_ABT_LSB + cur_reg[2:1]])
    else $error("aborted write left no flag");
  a_disable_drain: assert property (
    $fell(ctrl_eff_reg[0][0]) |-> !$past(busy_src[0]))
    else $error("disable took effect with write outstanding");
endmodule
`default_nettype wire

// [verilog/tuin_pkg.sv]
// constants and types shared by the translation-unit interrupt notifier
//
// Behaviour
// - a message interrupt is one 32-bit write of payload to destination
// - wired outputs, message writes, or both exist; never neither
// - read-only capability flag per security state shows message support
// - enabled source trigger pulses its own wired output when wired exist
// - triggers are edge events; no software-clearable pending state
// - global error register update visible no later than its interrupt
// - queue index readable no later than interrupt announcing new entries
// - sync consumption visible in index register no later than interrupt
// - each message source holds its own memory type and shareability
// - device or non-cacheable memory type forces outer shareable
// - secure sources write with ns at 0, non-secure with ns at 1
// - own writes carry fixed device id; client stream ids pass unchanged
// - write built from address, payload, shareability, type and enable
// - repeated events may merge without noticeable delay
// - without message support only the enable bit is used
// - disabling a source completes its earlier message writes first
// - sync waits for message writes from earlier syncs of its queue
// - write completes on response; abort sets the message abort flag
// - after re-enable messages use the newly programmed configuration
// - event queue interrupts fire on empty to non-empty transition
// - sync may request interrupt; address and payload come from command
// - global error interrupts fire when a new error becomes active
// - write sent only if enabled, supported and address nonzero
package tuin_pkg;
  // ==========================================================
  // sources: index bit 0 is the secure state, index>>1 the kind
  localparam int NSRC      = 6;
  localparam int K_EVTQ    = 0;
  localparam int K_SYNC    = 1;
  localparam int K_GERR    = 2;
  localparam int NKIND     = 3;
  localparam int DEVID_W   = 16;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CAP        = 8'h00;
  localparam logic [7:0] OFF_SCAP       = 8'h04;
  localparam logic [7:0] OFF_CTRL       = 8'h08;
  localparam logic [7:0] OFF_CTRL_ACK   = 8'h0c;
  localparam logic [7:0] OFF_SCTRL      = 8'h10;
  localparam logic [7:0] OFF_SCTRL_ACK  = 8'h14;
  localparam logic [7:0] OFF_GERR       = 8'h18;
  localparam logic [7:0] OFF_SGERR      = 8'h1c;
  localparam logic [7:0] OFF_EVTQ_PROD  = 8'h20;
  localparam logic [7:0] OFF_SEVTQ_PROD = 8'h24;
  localparam logic [7:0] OFF_CMDQ_CONS  = 8'h28;
  localparam logic [7:0] OFF_SCMDQ_CONS = 8'h2c;
  localparam logic [7:0] OFF_MSI_BASE   = 8'h40;
  localparam logic [1:0] SUB_ADDR       = 2'h0;
  localparam logic [1:0] SUB_DATA       = 2'h1;
  localparam logic [1:0] SUB_ATTR       = 2'h2;
  // ==========================================================
  // field positions
  localparam int CAP_MSI_BIT    = 0;
  localparam int CAP_WIRED_BIT  = 1;
  localparam int CAP_COH_ACC_BIT = 2;
  localparam int CAP_SECURE_BIT = 3;
  localparam int GERR_EXT_W     = 4;
  localparam int GERR_ABT_LSB   = 4;
  localparam int GERR_W         = 7;
  localparam int ATTR_SH_LSB    = 8;
  localparam logic [7:0] MT_NORMAL_NC = 8'h44;
  localparam logic [1:0] SH_OSH       = 2'h2;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  // ==========================================================
  // types
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [7:0]  memtype;
    logic [1:0]  sh;
  } tuin_msi_cfg_t;

  typedef struct packed {
    logic [31:0]        addr;
    logic [31:0]        data;
    logic [7:0]         memtype;
    logic [1:0]         sh;
    logic               ns;
    logic [DEVID_W-1:0] devid;
  } tuin_msi_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} tuin_state_t;
endpackage
